//--- dcp_pkg.sv
// Shared constants and types for the command and clock enable port
package dcp_pkg;

    localparam int          ADDR_W      = 16;
    localparam int          BANK_W      = 3;
    localparam int          NUM_BANKS   = 8;
    localparam int          LAT_W       = 4;
    localparam int          RLAT_W      = 5;
    localparam int          PIN_W       = 27;

    // Address bit positions
    localparam int          A_AUTO_PRE  = 10;
    localparam int          A_CHOP      = 12;

    // Latency limits in clocks
    localparam logic [3:0]  CL_MIN      = 4'h5;
    localparam logic [3:0]  CL_MAX      = 4'hB;
    localparam logic [3:0]  CWL_MIN     = 4'h5;
    localparam logic [3:0]  CWL_MAX     = 4'h9;

    // Additive latency selector codes
    localparam logic [1:0]  AL_ZERO     = 2'h0;
    localparam logic [1:0]  AL_CL_M1    = 2'h1;
    localparam logic [1:0]  AL_CL_M2    = 2'h2;

    // Burst lengths in beats
    localparam logic [3:0]  BURST_4     = 4'h4;
    localparam logic [3:0]  BURST_8     = 4'h8;

    // Mode register targets on the bank address
    localparam logic [2:0]  MR_BURST_CL = 3'h0;
    localparam logic [2:0]  MR_ADDLAT   = 3'h1;
    localparam logic [2:0]  MR_WRLAT    = 3'h2;

    // Reset values of the mode settings
    localparam logic [3:0]  CL_RST      = 4'h5;
    localparam logic [3:0]  CWL_RST     = 4'h5;
    localparam logic [1:0]  AL_RST      = 2'h0;
    localparam logic        BL8_RST     = 1'b1;
    localparam logic        IL_RST      = 1'b0;

    // Command code: {chip select, row strobe, column strobe, write enable}, all low true
    typedef enum logic [3:0] {
        CMD_MRS = 4'h0,
        CMD_REF = 4'h1,
        CMD_PRE = 4'h2,
        CMD_ACT = 4'h3,
        CMD_WR  = 4'h4,
        CMD_RD  = 4'h5,
        CMD_ZQC = 4'h6,
        CMD_NOP = 4'h7
    } dcp_cmd_t;

    // Power state, one-hot
    typedef enum logic [3:0] {
        ST_ACTIVE = 4'h1,
        ST_PPD    = 4'h2,
        ST_APD    = 4'h4,
        ST_SREF   = 4'h8
    } dcp_state_t;

endpackage

//--- dcp_bank_if.sv
// Carrier between the command decoder and the bank tracker
`timescale 1ns/1ps
interface dcp_bank_if;
    logic                        cmd_stb;
    dcp_pkg::dcp_cmd_t           cmd;
    logic [dcp_pkg::BANK_W-1:0]  bank;
    logic                        all_banks;
    logic [dcp_pkg::NUM_BANKS-1:0] open_rows;
    logic                        all_idle;

    modport ctl (output cmd_stb, cmd, bank, all_banks, input open_rows, all_idle);
    modport trk (input cmd_stb, cmd, bank, all_banks, output open_rows, all_idle);
endinterface

//--- dcp_bank_track.sv
// Open-row tracker for the eight internal banks
`timescale 1ns/1ps
module dcp_bank_track (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    // Decoded commands
    dcp_bank_if.trk   bank_if
);

    logic [dcp_pkg::NUM_BANKS-1:0] open_reg;
    logic [dcp_pkg::NUM_BANKS-1:0] open_next;
    logic [dcp_pkg::NUM_BANKS-1:0] sel;

    assign sel = dcp_pkg::NUM_BANKS'(1) << bank_if.bank;

    always_comb
    begin
        open_next = open_reg;
        if (bank_if.cmd_stb)
        begin
            unique case (bank_if.cmd)
                dcp_pkg::CMD_ACT: open_next = open_reg | sel;
                dcp_pkg::CMD_PRE:
                begin
                    if (bank_if.all_banks)
                        open_next = '0;
                    else
                        open_next = open_reg & ~sel;
                end
                default: open_next = open_reg;
            endcase
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            open_reg <= '0;
        else
            open_reg <= open_next;
    end

    assign bank_if.open_rows = open_reg;
    assign bank_if.all_idle  = ~|open_reg;

endmodule

//--- dcp_cmd_port.sv
// Command, clock enable and power state front end
`timescale 1ns/1ps
// Overview of operation
// - Sample inputs on clock rise, complement fall
// - Clock enable high runs clocks, buffers, drivers
// - Low enable: precharge/self-refresh or active power-down
// - Power-down entry/exit, refresh entry on crossings
// - Self-refresh exit taken from enable level alone
// - Power-down keeps clock, termination, enable buffers
// - Self-refresh keeps only enable buffer
// - Chip select high masks every command
// - Four command inputs form one code
// - Read latency programmable from 5 to 11
// - Write latency programmable from 5 to 9
// - Additive latency zero, CL-1 or CL-2
// - Burst length 4 or 8, two orders
// - Eight banks chosen by bank address
// - One column access supplies whole burst
// - Bank address picks bank or mode register
// - Address bit 12 low chops the burst
module dcp_cmd_port (
    // Clock and reset
    input  wire logic                        clk_in,
    input  wire logic                        rst_in,
    // Memory command pins
    input  wire logic                        ck_p_in,
    input  wire logic                        ck_n_in,
    input  wire logic                        cke_in,
    input  wire logic                        cs_n_in,
    input  wire logic                        ras_n_in,
    input  wire logic                        cas_n_in,
    input  wire logic                        we_n_in,
    input  wire logic                        odt_in,
    input  wire logic [dcp_pkg::BANK_W-1:0]  ba_in,
    input  wire logic [dcp_pkg::ADDR_W-1:0]  addr_in,
    // Mode settings offered to a mode register set
    input  wire logic [dcp_pkg::LAT_W-1:0]   cl_in,
    input  wire logic [dcp_pkg::LAT_W-1:0]   cwl_in,
    input  wire logic [1:0]                  al_sel_in,
    input  wire logic                        bl8_in,
    input  wire logic                        burst_il_in,
    // Power and buffer controls
    output logic                             clk_run_out,
    output logic                             out_drv_en_out,
    output logic                             ck_buf_en_out,
    output logic                             cmd_buf_en_out,
    output logic                             odt_buf_en_out,
    output logic                             cke_buf_en_out,
    output logic [3:0]                       pwr_state_out,
    output logic                             odt_out,
    // Decoded commands
    output logic                             cmd_valid_out,
    output logic [3:0]                       cmd_out,
    output logic [dcp_pkg::BANK_W-1:0]       bank_out,
    output logic [dcp_pkg::ADDR_W-1:0]       addr_out,
    output logic                             col_access_out,
    output logic                             chop_out,
    output logic [3:0]                       burst_len_out,
    output logic [dcp_pkg::NUM_BANKS-1:0]    bank_open_out,
    // Active mode settings
    output logic [dcp_pkg::RLAT_W-1:0]       rd_lat_out,
    output logic [dcp_pkg::RLAT_W-1:0]       wr_lat_out,
    output logic                             burst_il_out,
    output logic                             cfg_err_out
);

    dcp_bank_if bank_if ();

    // Pin synchroniser
    logic [dcp_pkg::PIN_W-1:0] pin_raw;
    logic [dcp_pkg::PIN_W-1:0] pin_meta_reg;
    logic [dcp_pkg::PIN_W-1:0] pin_reg;

    assign pin_raw = {ck_p_in, ck_n_in, cke_in, cs_n_in, ras_n_in, cas_n_in,
                      we_n_in, odt_in, ba_in, addr_in};

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            pin_meta_reg <= '0;
            pin_reg      <= '0;
        end
        else
        begin
            pin_meta_reg <= pin_raw;
            pin_reg      <= pin_meta_reg;
        end
    end

    logic                       ck_p;
    logic                       ck_n;
    logic                       cke;
    logic [3:0]                 code;
    logic                       odt;
    logic [dcp_pkg::BANK_W-1:0] ba;
    logic [dcp_pkg::ADDR_W-1:0] addr;

    assign {ck_p, ck_n, cke, code, odt, ba, addr} = pin_reg;

    // Clock crossing detect
    logic ck_p_prev_reg;
    logic xing;

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            ck_p_prev_reg <= 1'b0;
        else
            ck_p_prev_reg <= ck_p;
    end

    dcp_pkg::dcp_state_t state_reg;
    dcp_pkg::dcp_state_t state_next;
    logic                st_active;
    logic                st_sref;

    assign st_active = (state_reg == dcp_pkg::ST_ACTIVE);
    assign st_sref   = (state_reg == dcp_pkg::ST_SREF);

    assign xing = ck_p & ~ck_p_prev_reg & ~ck_n & ~st_sref;

    // Command acceptance
    logic cmd_hit;
    logic is_col;

    assign cmd_hit = xing & st_active & cke & ~code[3];
    assign is_col  = (code == dcp_pkg::CMD_RD) || (code == dcp_pkg::CMD_WR);

    assign bank_if.cmd_stb   = cmd_hit;
    assign bank_if.cmd       = dcp_pkg::dcp_cmd_t'(code);
    assign bank_if.bank      = ba;
    assign bank_if.all_banks = addr[dcp_pkg::A_AUTO_PRE];

    dcp_bank_track u_bank_track (
        .clk_in  (clk_in),
        .rst_in  (rst_in),
        .bank_if (bank_if)
    );

    // Power state machine
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            dcp_pkg::ST_ACTIVE:
            begin
                if (xing && !cke)
                begin
                    if (code == dcp_pkg::CMD_REF)
                        state_next = dcp_pkg::ST_SREF;
                    else if (bank_if.all_idle)
                        state_next = dcp_pkg::ST_PPD;
                    else
                        state_next = dcp_pkg::ST_APD;
                end
            end
            dcp_pkg::ST_PPD, dcp_pkg::ST_APD:
            begin
                if (xing && cke)
                    state_next = dcp_pkg::ST_ACTIVE;
            end
            dcp_pkg::ST_SREF:
            begin
                if (cke)
                    state_next = dcp_pkg::ST_ACTIVE;
            end
            default: state_next = dcp_pkg::ST_ACTIVE;
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            state_reg <= dcp_pkg::ST_ACTIVE;
        else
            state_reg <= state_next;
    end

    // Clock and buffer gating
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            clk_run_out    <= 1'b1;
            out_drv_en_out <= 1'b1;
            cmd_buf_en_out <= 1'b1;
            ck_buf_en_out  <= 1'b1;
            odt_buf_en_out <= 1'b1;
        end
        else
        begin
            clk_run_out    <= (state_next == dcp_pkg::ST_ACTIVE);
            out_drv_en_out <= (state_next == dcp_pkg::ST_ACTIVE);
            cmd_buf_en_out <= (state_next == dcp_pkg::ST_ACTIVE);
            ck_buf_en_out  <= (state_next != dcp_pkg::ST_SREF);
            odt_buf_en_out <= (state_next != dcp_pkg::ST_SREF);
        end
    end

    assign cke_buf_en_out = 1'b1;
    assign pwr_state_out  = state_reg;

    // Termination input, frozen while its buffer is off
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            odt_out <= 1'b0;
        else if (xing && !st_sref)
            odt_out <= odt;
    end

    // Mode settings
    logic [dcp_pkg::LAT_W-1:0] cl_reg;
    logic [dcp_pkg::LAT_W-1:0] cwl_reg;
    logic [1:0]                al_reg;
    logic                      bl8_reg;
    logic                      il_reg;
    logic                      mrs_hit;
    logic                      cl_ok;
    logic                      cwl_ok;
    logic                      al_ok;

    assign mrs_hit = cmd_hit && (code == dcp_pkg::CMD_MRS);
    assign cl_ok   = (cl_in >= dcp_pkg::CL_MIN) && (cl_in <= dcp_pkg::CL_MAX);
    assign cwl_ok  = (cwl_in >= dcp_pkg::CWL_MIN) && (cwl_in <= dcp_pkg::CWL_MAX);
    assign al_ok   = (al_sel_in != 2'h3);

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            cl_reg      <= dcp_pkg::CL_RST;
            bl8_reg     <= dcp_pkg::BL8_RST;
            il_reg      <= dcp_pkg::IL_RST;
            al_reg      <= dcp_pkg::AL_RST;
            cwl_reg     <= dcp_pkg::CWL_RST;
            cfg_err_out <= 1'b0;
        end
        else if (mrs_hit)
        begin
            cfg_err_out <= 1'b0;
            unique case (ba)
                dcp_pkg::MR_BURST_CL:
                begin
                    bl8_reg <= bl8_in;
                    il_reg  <= burst_il_in;
                    if (cl_ok)
                        cl_reg <= cl_in;
                    else
                        cfg_err_out <= 1'b1;
                end
                dcp_pkg::MR_ADDLAT:
                begin
                    if (al_ok)
                        al_reg <= al_sel_in;
                    else
                        cfg_err_out <= 1'b1;
                end
                dcp_pkg::MR_WRLAT:
                begin
                    if (cwl_ok)
                        cwl_reg <= cwl_in;
                    else
                        cfg_err_out <= 1'b1;
                end
                default: cfg_err_out <= 1'b0;
            endcase
        end
    end

    // Effective latencies
    logic [dcp_pkg::RLAT_W-1:0] al_cyc;

    always_comb
    begin
        unique case (al_reg)
            dcp_pkg::AL_CL_M1: al_cyc = dcp_pkg::RLAT_W'(cl_reg - 4'h1);
            dcp_pkg::AL_CL_M2: al_cyc = dcp_pkg::RLAT_W'(cl_reg - 4'h2);
            default:           al_cyc = '0;
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            rd_lat_out <= dcp_pkg::RLAT_W'(dcp_pkg::CL_RST);
            wr_lat_out <= dcp_pkg::RLAT_W'(dcp_pkg::CWL_RST);
        end
        else
        begin
            rd_lat_out <= al_cyc + dcp_pkg::RLAT_W'(cl_reg);
            wr_lat_out <= al_cyc + dcp_pkg::RLAT_W'(cwl_reg);
        end
    end

    assign burst_il_out = il_reg;

    // Decoded command outputs
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            cmd_valid_out  <= 1'b0;
            col_access_out <= 1'b0;
            cmd_out        <= dcp_pkg::CMD_NOP;
            bank_out       <= '0;
            addr_out       <= '0;
            chop_out       <= 1'b0;
            burst_len_out  <= dcp_pkg::BURST_8;
        end
        else
        begin
            cmd_valid_out  <= cmd_hit;
            col_access_out <= cmd_hit && is_col;
            if (cmd_hit)
            begin
                cmd_out  <= code;
                bank_out <= ba;
                addr_out <= addr;
            end
            if (cmd_hit && is_col)
            begin
                chop_out <= bl8_reg && !addr[dcp_pkg::A_CHOP];
                if (bl8_reg && addr[dcp_pkg::A_CHOP])
                    burst_len_out <= dcp_pkg::BURST_8;
                else
                    burst_len_out <= dcp_pkg::BURST_4;
            end
        end
    end

    assign bank_open_out = bank_if.open_rows;

endmodule

//--- dcp_cmd_checker.sv
// Assertion checker for the command and clock enable port
`timescale 1ns/1ps
module dcp_cmd_checker (
    // Clock and reset
    input  wire logic                         clk_in,
    input  wire logic                         rst_in,
    // Enable pin and power controls
    input  wire logic                         cke_in,
    input  wire logic                         clk_run_out,
    input  wire logic                         out_drv_en_out,
    input  wire logic                         ck_buf_en_out,
    input  wire logic                         cmd_buf_en_out,
    input  wire logic                         odt_buf_en_out,
    input  wire logic                         cke_buf_en_out,
    input  wire logic [3:0]                   pwr_state_out,
    // Decoded commands
    input  wire logic                         cmd_valid_out,
    input  wire logic [3:0]                   cmd_out,
    input  wire logic [dcp_pkg::BANK_W-1:0]   bank_out,
    input  wire logic                         col_access_out,
    input  wire logic                         chop_out,
    input  wire logic [3:0]                   burst_len_out,
    input  wire logic [dcp_pkg::NUM_BANKS-1:0] bank_open_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    a_cs_mask: assert property (cmd_valid_out |-> !cmd_out[3])
        else $error("command accepted with chip select high");
    a_col_pulse: assert property (col_access_out |-> cmd_valid_out && cmd_out[3:1] == 3'h2)
        else $error("column access without read or write");
    a_one_pulse: assert property (cmd_valid_out |=> !cmd_valid_out)
        else $error("command pulse longer than one cycle");
    a_active_runs: assert property (pwr_state_out == 4'h1 |-> clk_run_out
        && out_drv_en_out && cmd_buf_en_out) else $error("active state with clocks stopped");
    a_low_stops: assert property (pwr_state_out != 4'h1 |-> !clk_run_out
        && !out_drv_en_out && !cmd_buf_en_out) else $error("low power state with clocks running");
    a_pd_keeps: assert property ((pwr_state_out == 4'h2 || pwr_state_out == 4'h4) |->
        ck_buf_en_out && odt_buf_en_out && cke_buf_en_out) else $error("power-down buffers");
    a_sref_bufs: assert property (pwr_state_out == 4'h8 |-> !ck_buf_en_out
        && !odt_buf_en_out && cke_buf_en_out) else $error("self-refresh buffers wrong");
    a_no_cmd_low: assert property (cmd_valid_out |-> $past(pwr_state_out) == 4'h1)
        else $error("command accepted outside active state");
    a_sref_exit: assert property (pwr_state_out == 4'h8 && cke_in |->
        ##[1:4] pwr_state_out == 4'h1)
        else $error("self-refresh exit too slow");
    a_chop_len: assert property (chop_out |-> burst_len_out == 4'h4)
        else $error("chopped burst not four beats");
    a_bank_open: assert property (cmd_valid_out && cmd_out == 4'h3 |->
        ##[0:2] bank_open_out[bank_out])
        else $error("activated bank not open");
    a_ppd_idle: assert property (pwr_state_out == 4'h2 |-> bank_open_out == 8'h00)
        else $error("precharge power-down with open row");
    a_apd_open: assert property (pwr_state_out == 4'h4 |-> bank_open_out != 8'h00)
        else $error("active power-down with no open row");
endmodule

bind dcp_cmd_port dcp_cmd_checker i_chk (
    .clk_in, .rst_in, .cke_in, .clk_run_out, .out_drv_en_out, .ck_buf_en_out,
    .cmd_buf_en_out, .odt_buf_en_out, .cke_buf_en_out, .pwr_state_out, .cmd_valid_out,
    .cmd_out, .bank_out, .col_access_out, .chop_out, .burst_len_out, .bank_open_out
);

//--- dcp_ctl_model.sv
// Behavioural model of the memory controller driving clock and command pins
`timescale 1ns/1ps
module dcp_ctl_model (
    // System clock
    input  wire logic         clk_in,
    // Memory pins
    output logic              ck_p_out,
    output logic              ck_n_out,
    output logic              cke_out,
    output logic              cs_n_out,
    output logic              ras_n_out,
    output logic              cas_n_out,
    output logic              we_n_out,
    output logic              odt_out,
    output logic [2:0]        ba_out,
    output logic [15:0]       addr_out
);
    initial
    begin
        {ck_p_out, ck_n_out, cke_out, cs_n_out} = 4'h7;
        {ras_n_out, cas_n_out, we_n_out, odt_out} = 4'hF;
        {ba_out, addr_out} = 19'h00000;
    end

    // One clock pulse per command, pins stable around the rise
    task automatic send(input logic [3:0] c, input logic [2:0] b, input logic [15:0] a,
                        input logic k, input logic o);
        @(negedge clk_in);
        {cs_n_out, ras_n_out, cas_n_out, we_n_out} = c;
        ba_out = b;
        addr_out = a;
        cke_out = k;
        odt_out = o;
        repeat (3) @(negedge clk_in);
        {ck_p_out, ck_n_out} = 2'h2;
        repeat (4) @(negedge clk_in);
        {ck_p_out, ck_n_out} = 2'h1;
        repeat (3) @(negedge clk_in);
        {cs_n_out, ras_n_out, cas_n_out, we_n_out} = ~c;
        ba_out = ~b;
        addr_out = ~a;
        odt_out = ~o;
    endtask

    // Enable change with the clock stopped
    task automatic set_cke(input logic k);
        @(negedge clk_in);
        cke_out = k;
    endtask
endmodule

//--- testbench.sv
// Self-checking testbench for the command and clock enable port
`timescale 1ns/1ps
module testbench;
    logic                          clk_in = 1'b0;
    logic                          rst_in = 1'b1;
    logic                          ck_p_in, ck_n_in, cke_in, cs_n_in, ras_n_in, cas_n_in;
    logic                          we_n_in, odt_in, bl8_in, burst_il_in, odt_out, chop_out;
    logic [dcp_pkg::BANK_W-1:0]    ba_in, bank_out;
    logic [dcp_pkg::ADDR_W-1:0]    addr_in, addr_out;
    logic [dcp_pkg::LAT_W-1:0]     cl_in, cwl_in;
    logic [1:0]                    al_sel_in;
    logic                          clk_run_out, out_drv_en_out, ck_buf_en_out, cmd_buf_en_out;
    logic                          odt_buf_en_out, cke_buf_en_out, cmd_valid_out, col_access_out;
    logic                          burst_il_out, cfg_err_out;
    logic [3:0]                    pwr_state_out, cmd_out, burst_len_out;
    logic [dcp_pkg::NUM_BANKS-1:0] bank_open_out;
    logic [dcp_pkg::RLAT_W-1:0]    rd_lat_out, wr_lat_out;
    logic [23:0]                   exp_q[$];
    logic [23:0]                   got;
    logic [9:0]                    lat_e;
    int                            error_cnt = 0;
    int                            checks_done = 0;
    int                            n;

    always #4 clk_in = ~clk_in;

    dcp_cmd_port i_dut (
        .clk_in, .rst_in, .ck_p_in, .ck_n_in, .cke_in, .cs_n_in, .ras_n_in, .cas_n_in,
        .we_n_in, .odt_in, .ba_in, .addr_in, .cl_in, .cwl_in, .al_sel_in, .bl8_in,
        .burst_il_in, .clk_run_out, .out_drv_en_out, .ck_buf_en_out, .cmd_buf_en_out,
        .odt_buf_en_out, .cke_buf_en_out, .pwr_state_out, .odt_out, .cmd_valid_out, .cmd_out,
        .bank_out, .addr_out, .col_access_out, .chop_out, .burst_len_out, .bank_open_out,
        .rd_lat_out, .wr_lat_out, .burst_il_out, .cfg_err_out
    );

    dcp_ctl_model i_ctl (
        .clk_in, .ck_p_out(ck_p_in), .ck_n_out(ck_n_in), .cke_out(cke_in), .cs_n_out(cs_n_in),
        .ras_n_out(ras_n_in), .cas_n_out(cas_n_in), .we_n_out(we_n_in), .odt_out(odt_in),
        .ba_out(ba_in), .addr_out(addr_in)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Expected latency: base plus additive latency of the pending settings
    function automatic logic [9:0] lat();
        logic [4:0] al;
        al = al_sel_in == 2'h1 ? 5'(cl_in) - 5'h1 : al_sel_in == 2'h2 ? 5'(cl_in) - 5'h2 : 5'h0;
        return {5'(cl_in) + al, 5'(cwl_in) + al};
    endfunction

    task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [15:0] a,
                         input logic k, input logic acc);
        logic o;
        o = 1'($urandom);
        if (acc)
            exp_q.push_back({c, b, a, o});
        i_ctl.send(c, b, a, k, o);
    endtask

    task automatic mrs(input logic [2:0] b);
        issue(4'h0, b, 16'($urandom), 1'b1, 1'b1);
    endtask

    // Each accepted command is matched against the oldest note
    always @(negedge clk_in)
    begin
        if (!rst_in && cmd_valid_out === 1'b1)
        begin
            if (exp_q.size() == 0)
                check(32'h1, 32'h0);
            else
            begin
                got = exp_q.pop_front();
                check({cmd_out, bank_out, addr_out, odt_out, col_access_out},
                      {got, got[23:21] == 3'h2});
            end
        end
    end

    initial
    begin
        {cl_in, cwl_in, al_sel_in, bl8_in, burst_il_in} = {4'h5, 4'h5, 2'h0, 1'b1, 1'b0};
        void'($urandom(32'h6fbe));
        repeat (6) @(negedge clk_in);
        rst_in = 1'b0;
        repeat (3) @(negedge clk_in);
        check(pwr_state_out, 4'h1);
        check({rd_lat_out, wr_lat_out, burst_len_out, burst_il_out, cfg_err_out},
              {5'h5, 5'h5, 4'h8, 2'h0});
        check({cmd_out, bank_open_out}, {4'h7, 8'h00});
        $display("test reset done");
        for (int i = 0; i < 3; i++)
        begin
            cl_in = 4'h5 + 4'($urandom_range(6));
            cwl_in = 4'h5 + 4'($urandom_range(4));
            al_sel_in = 2'(i);
            burst_il_in = i[0];
            for (int b = 0; b < 3; b++)
                mrs(3'(b));
            lat_e = lat();
            check({rd_lat_out, wr_lat_out, burst_il_out, cfg_err_out}, {lat_e, i[0], 1'b0});
        end
        {cl_in, cwl_in, al_sel_in} = {4'hC, 4'hA, 2'h3};
        for (int b = 0; b < 3; b++)
        begin
            mrs(3'(b));
            check({rd_lat_out, wr_lat_out, cfg_err_out}, {lat_e, 1'b1});
        end
        {cl_in, cwl_in, al_sel_in} = {4'hB, 4'h9, 2'h2};
        for (int b = 0; b < 3; b++)
            mrs(3'(b));
        check({rd_lat_out, wr_lat_out, cfg_err_out}, {5'h14, 5'h12, 1'b0});
        rst_in = 1'b1;
        repeat (3) @(negedge clk_in);
        rst_in = 1'b0;
        repeat (3) @(negedge clk_in);
        check({rd_lat_out, wr_lat_out}, {5'h5, 5'h5});
        $display("test mode done");
        for (int b = 0; b < 8; b++)
            issue(4'h3, 3'(b), 16'($urandom), 1'b1, 1'b1);
        check(bank_open_out, 8'hFF);
        issue(4'h5, 3'h2, 16'($urandom) & 16'hEFFF, 1'b1, 1'b1);
        check({chop_out, burst_len_out}, {1'b1, 4'h4});
        issue(4'h4, 3'h5, 16'($urandom) | 16'h1000, 1'b1, 1'b1);
        check({chop_out, burst_len_out}, {1'b0, 4'h8});
        issue(4'hA, 3'h1, 16'h0400, 1'b1, 1'b0);
        check(bank_open_out, 8'hFF);
        issue(4'h2, 3'h0, 16'h0400, 1'b1, 1'b1);
        check(bank_open_out, 8'h00);
        for (int c = 5; c < 8; c++)
            issue(c == 5 ? 4'h1 : 4'(c), 3'(c), 16'($urandom), 1'b1, 1'b1);
        bl8_in = 1'b0;
        mrs(3'h0);
        issue(4'h5, 3'h3, 16'h0000, 1'b1, 1'b1);
        check({chop_out, burst_len_out}, {1'b0, 4'h4});
        bl8_in = 1'b1;
        mrs(3'h0);
        $display("test commands done");
        issue(4'h3, 3'h2, 16'($urandom), 1'b1, 1'b1);
        issue(4'h7, 3'h0, 16'h0000, 1'b0, 1'b0);
        check({pwr_state_out, cmd_buf_en_out, ck_buf_en_out}, {4'h4, 2'h1});
        issue(4'h5, 3'h2, 16'h0000, 1'b0, 1'b0);
        check(pwr_state_out, 4'h4);
        issue(4'h7, 3'h0, 16'h0000, 1'b1, 1'b0);
        check({pwr_state_out, clk_run_out, out_drv_en_out}, {4'h1, 2'h3});
        issue(4'h2, 3'h0, 16'h0400, 1'b1, 1'b1);
        issue(4'h7, 3'h0, 16'h0000, 1'b0, 1'b0);
        check({pwr_state_out, odt_buf_en_out}, {4'h2, 1'b1});
        issue(4'h7, 3'h0, 16'h0000, 1'b1, 1'b0);
        issue(4'h1, 3'h0, 16'h0000, 1'b0, 1'b0);
        check({pwr_state_out, ck_buf_en_out, odt_buf_en_out, cke_buf_en_out},
              {4'h8, 3'h1});
        i_ctl.set_cke(1'b1);
        for (n = 0; n < 10 && pwr_state_out !== 4'h1; n++)
            @(negedge clk_in);
        check(pwr_state_out, 4'h1);
        if (n == 10)
            conclude();
        issue(4'h7, 3'h4, 16'($urandom), 1'b1, 1'b1);
        $display("test power done");
        check(exp_q.size(), 0);
        conclude();
    end
endmodule
